// ===== ext_bus_pins.sv
`timescale 1ns/1ps
module ext_bus_pins
   import ext_bus_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // device pins, sampled
   input  wire logic              reset_in_n,
   input  wire logic              hold_req_n,
   input  wire logic              out_disable_n,
   input  wire logic              host_port_wide_select,
   // core access request
   input  wire logic              core_req,
   input  wire logic              core_write,
   input  wire logic [1:0]        core_space,
   input  wire logic [ADDR_W-1:0] core_addr,
   input  wire logic [DATA_W-1:0] core_wdata,
   output logic [DATA_W-1:0]      core_rdata,
   // host access port side
   input  wire logic              host_read,
   input  wire logic [DATA_W-1:0] host_rdata,
   output logic [HOST_ADDR_W-1:0] host_addr,
   output logic [DATA_W-1:0]      host_wdata,
   // bank-switch control holder settings
   input  wire logic              bank_switch_ctrl_reg_addr_hold,
   input  wire logic              bank_switch_ctrl_reg_data_hold,
   // status
   output logic                   hold_ack,
   // address pins
   input  wire logic [ADDR_W-1:0] ext_addr_lines_i,
   output logic [ADDR_W-1:0]      ext_addr_lines_o,
   output logic [ADDR_W-1:0]      ext_addr_lines_oe,
   output logic [ADDR_W-1:0]      addr_keeper_o,
   output logic                   addr_keeper_en,
   // data pins
   input  wire logic [DATA_W-1:0] ext_data_lines_i,
   output logic [DATA_W-1:0]      ext_data_lines_o,
   output logic                   ext_data_lines_oe,
   output logic [DATA_W-1:0]      data_keeper_o,
   output logic                   data_keeper_en
);
   pin_sync_if ps ();

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   assign ps.addr_raw = ext_addr_lines_i;
   assign ps.data_raw = ext_data_lines_i;
   assign ps.ctl_raw  = {reset_in_n, hold_req_n, out_disable_n, host_port_wide_select};

   pin_sync u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .p       (ps.syncer)
   );

   logic rst_s, hold_s, off_s, wide_s;
   assign rst_s  = ~ps.ctl_sync[3];
   assign hold_s = ~ps.ctl_sync[2];
   assign off_s  = ~ps.ctl_sync[1];
   assign wide_s = ps.ctl_sync[0];

   // ------------------------------------------------------------
   // bus state
   // ------------------------------------------------------------
   bus_state_t        state_reg, state_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic              dout_en_reg, dout_en_next;
   logic [ADDR_W-1:0] aoe_reg, aoe_next;
   logic [ADDR_W-1:0] alast_reg, alast_next;
   logic [DATA_W-1:0] dlast_reg, dlast_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [HOST_ADDR_W-1:0] haddr_reg, haddr_next;
   logic [DATA_W-1:0] hwdata_reg, hwdata_next;
   logic              ahold_reg, ahold_next;
   logic              dhold_reg, dhold_next;

   always_comb begin
      state_next   = state_reg;
      addr_next    = addr_reg;
      dout_next    = dout_reg;
      dout_en_next = 1'b0;
      aoe_next     = '0;
      rdata_next   = rdata_reg;
      haddr_next   = haddr_reg;
      hwdata_next  = hwdata_reg;
      ahold_next   = bank_switch_ctrl_reg_addr_hold;
      dhold_next   = bank_switch_ctrl_reg_data_hold;
      case (state_reg)
         BUS_RESET: state_next = BUS_DRIVE;
         BUS_DRIVE,
         BUS_FLOAT,
         BUS_HOST:  state_next = BUS_DRIVE;
         default:   state_next = BUS_RESET;
      endcase
      if (rst_s)
         state_next = BUS_RESET;
      else if (wide_s)
         state_next = BUS_HOST;
      else if (hold_s || off_s)
         state_next = BUS_FLOAT;

      case (state_next)
         BUS_DRIVE: begin
            if (core_req) begin
               // upper lines extend program space only
               if (core_space == SPACE_PROG)
                  addr_next = core_addr;
               else
                  addr_next = {{(ADDR_W-LOW_ADDR_W){1'b0}}, core_addr[LOW_ADDR_W-1:0]};
               aoe_next = '1;
               dout_en_next = core_write;
               if (core_write)
                  dout_next = core_wdata;
            end
            if (off_s)
               aoe_next = '0;
         end
         BUS_HOST: begin
            // host owns the low lines; upper lines stay floated too
            aoe_next = '0;
            haddr_next = ps.addr_sync[HOST_ADDR_W-1:0];
            hwdata_next = ps.data_sync;
            // a hold request floats the data bus even for host reads
            if (host_read && !off_s && !hold_s) begin
               dout_next = host_rdata;
               dout_en_next = 1'b1;
            end
         end
         default: begin
            aoe_next = '0;
            dout_en_next = 1'b0;
         end
      endcase
      if (core_req && !core_write && state_reg == BUS_DRIVE)
         rdata_next = ps.data_sync;
   end

   // last level driven onto each line by the device; received levels are not kept
   always_comb begin
      alast_next = alast_reg;
      dlast_next = dlast_reg;
      for (int i = 0; i < ADDR_W; i++) begin
         alast_next[i] = aoe_reg[i] ? addr_reg[i] : alast_reg[i];
      end
      if (dout_en_reg)
         dlast_next = dout_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg   <= BUS_RESET;
         addr_reg    <= ADDR_RST;
         dout_reg    <= DATA_RST;
         dout_en_reg <= 1'b0;
         aoe_reg     <= '0;
         alast_reg   <= ADDR_RST;
         dlast_reg   <= DATA_RST;
         rdata_reg   <= DATA_RST;
         haddr_reg   <= '0;
         hwdata_reg  <= DATA_RST;
         ahold_reg   <= HOLDER_EN_RST;
         dhold_reg   <= HOLDER_EN_RST;
      end else begin
         state_reg   <= state_next;
         addr_reg    <= addr_next;
         dout_reg    <= dout_next;
         dout_en_reg <= dout_en_next;
         aoe_reg     <= aoe_next;
         alast_reg   <= alast_next;
         dlast_reg   <= dlast_next;
         rdata_reg   <= rdata_next;
         haddr_reg   <= haddr_next;
         hwdata_reg  <= hwdata_next;
         ahold_reg   <= ahold_next;
         dhold_reg   <= dhold_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // the keepers are weak drives; the testbench resolves them below oe
   assign ext_addr_lines_o  = addr_reg;
   assign ext_addr_lines_oe = aoe_reg;
   assign addr_keeper_o     = alast_reg;
   assign addr_keeper_en    = ahold_reg;
   assign ext_data_lines_o  = dout_reg;
   assign ext_data_lines_oe = dout_en_reg;
   assign data_keeper_o     = dlast_reg;
   assign data_keeper_en    = dhold_reg;
   assign core_rdata        = rdata_reg;
   assign host_addr         = haddr_reg;
   assign host_wdata        = hwdata_reg;
   assign hold_ack          = (state_reg == BUS_FLOAT) && hold_s;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence hold_seen;
      hold_s && !rst_s && !wide_s;
   endsequence

   AST_HOLD_FLOATS_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
      hold_seen |=> (ext_addr_lines_oe == '0))
      else $error("address driven during hold");
   AST_OFF_FLOATS_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
      off_s |=> (ext_addr_lines_oe == '0))
      else $error("address driven while outputs disabled");
   AST_WIDE_NO_ADDR_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
      wide_s && !rst_s |=> (ext_addr_lines_oe[HOST_ADDR_W-1:0] == '0))
      else $error("host-driven lines driven");
   AST_HOST_ADDR_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
      wide_s && !rst_s |=> host_addr == $past(ps.addr_sync[HOST_ADDR_W-1:0]))
      else $error("host address not captured");
   AST_DATA_SPACE_UPPER_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      !rst_s && !wide_s && !hold_s && !off_s && core_req && core_space != SPACE_PROG
      |=> ext_addr_lines_o[ADDR_W-1:LOW_ADDR_W] == '0)
      else $error("upper address used outside program space");
   AST_LOW_ADDR_SHARED: assert property (@(posedge clk) disable iff (sys_rst)
      !rst_s && !wide_s && !hold_s && !off_s && core_req
      |=> ext_addr_lines_o[LOW_ADDR_W-1:0] == $past(core_addr[LOW_ADDR_W-1:0]))
      else $error("low address not presented");
   AST_DATA_FLOAT: assert property (@(posedge clk) disable iff (sys_rst)
      (rst_s || hold_s || (!wide_s && !core_write)) |=> !ext_data_lines_oe)
      else $error("data driven when it must float");
   AST_OFF_FLOATS_DATA: assert property (@(posedge clk) disable iff (sys_rst)
      off_s |=> !ext_data_lines_oe)
      else $error("data driven while outputs disabled");
   AST_DATA_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      ext_data_lines_oe ##1 !ext_data_lines_oe |-> data_keeper_o == $past(ext_data_lines_o))
      else $error("data keeper lost last level");
   AST_ADDR_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      ext_addr_lines_oe[0] ##1 !ext_addr_lines_oe[0]
      |-> addr_keeper_o[0] == $past(ext_addr_lines_o[0]))
      else $error("address keeper lost last level");
   AST_HOLDER_CTRL: assert property (@(posedge clk) disable iff (sys_rst)
      data_keeper_en == $past(bank_switch_ctrl_reg_data_hold, 1) || $past(sys_rst))
      else $error("data holder control not followed");
endmodule

// ===== ext_bus_pkg.sv
package ext_bus_pkg;
   localparam int ADDR_W     = 23;
   localparam int LOW_ADDR_W = 16;
   localparam int HOST_ADDR_W = 18;
   localparam int DATA_W     = 16;
   // address space selects
   localparam logic [1:0] SPACE_PROG = 2'h0;
   localparam logic [1:0] SPACE_DATA = 2'h1;
   localparam logic [1:0] SPACE_IO   = 2'h2;
   // holder reset: enabled
   localparam logic HOLDER_EN_RST = 1'b1;
   localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   typedef enum logic [1:0] {
      BUS_RESET = 2'b00,
      BUS_DRIVE = 2'b01,
      BUS_FLOAT = 2'b10,
      BUS_HOST  = 2'b11
   } bus_state_t;
endpackage

// ===== pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if;
   import ext_bus_pkg::*;
   logic [ADDR_W-1:0] addr_raw;
   logic [DATA_W-1:0] data_raw;
   logic [3:0]        ctl_raw;
   logic [ADDR_W-1:0] addr_sync;
   logic [DATA_W-1:0] data_sync;
   logic [3:0]        ctl_sync;
   modport syncer (input addr_raw, data_raw, ctl_raw, output addr_sync, data_sync, ctl_sync);
   modport user   (output addr_raw, data_raw, ctl_raw, input addr_sync, data_sync, ctl_sync);
endinterface

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync
   import ext_bus_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // pins
   pin_sync_if.syncer p
);
   localparam int W = ADDR_W + DATA_W + 4;
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage1_next;
   logic [W-1:0] stage2_next;

   always_comb begin
      stage1_next = {p.addr_raw, p.data_raw, p.ctl_raw};
      stage2_next = stage1_reg;
   end

   // first stage feeds the second only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign p.addr_sync = stage2_reg[W-1 -: ADDR_W];
   assign p.data_sync = stage2_reg[DATA_W+3 -: DATA_W];
   assign p.ctl_sync  = stage2_reg[3:0];
endmodule

// ===== ext_far_side.sv
`timescale 1ns/1ps
module ext_far_side
   import ext_bus_pkg::*;
(
   // clock
   input  wire logic                   clk,
   // scenario control
   input  wire logic                   mem_drive,
   input  wire logic [DATA_W-1:0]      mem_word,
   input  wire logic                   host_drive,
   input  wire logic [HOST_ADDR_W-1:0] host_word,
   // device pin side
   input  wire logic [ADDR_W-1:0]      a_o,
   input  wire logic [ADDR_W-1:0]      a_oe,
   input  wire logic [ADDR_W-1:0]      a_keep,
   input  wire logic                   a_keep_en,
   input  wire logic [DATA_W-1:0]      d_o,
   input  wire logic                   d_oe,
   input  wire logic [DATA_W-1:0]      d_keep,
   input  wire logic                   d_keep_en,
   // resolved wire levels
   output logic      [ADDR_W-1:0]      a_pin,
   output logic      [DATA_W-1:0]      d_pin
);
   logic [ADDR_W-1:0] a_last;
   logic [DATA_W-1:0] d_last;
   // a released, unkept line shows the inverse of the last level the device (or, on data lines, the memory) drove onto it,
   // so stale values never pass
   always_comb begin
      for (int i = 0; i < ADDR_W; i++) begin
         if (host_drive && i < HOST_ADDR_W) begin
            a_pin[i] = a_oe[i] ? 1'bx : host_word[i];
         end else begin
            a_pin[i] = a_oe[i] ? a_o[i] : (a_keep_en ? a_keep[i] : ~a_last[i]);
         end
      end
      // contention on the data bus shows up as unknown
      if (d_oe) begin
         d_pin = mem_drive ? 'x : d_o;
      end else if (mem_drive) begin
         d_pin = mem_word;
      end else begin
         d_pin = d_keep_en ? d_keep : ~d_last;
      end
   end
   always_ff @(posedge clk) begin
      for (int i = 0; i < ADDR_W; i++) begin
         a_last[i] <= a_oe[i] ? a_o[i] : a_last[i];
      end
      d_last <= d_oe ? d_o : (mem_drive ? mem_word : d_last);
   end
endmodule

// ===== external_bus_pin_control_tb.sv
`timescale 1ns/1ps
module external_bus_pin_control_tb
   import ext_bus_pkg::*;
;
   logic clk, sys_rst, reset_in_n, hold_req_n, out_disable_n, host_port_wide_select;
   logic core_req, core_write, host_read, hold_ack, addr_keeper_en, data_keeper_en;
   logic bank_switch_ctrl_reg_addr_hold, bank_switch_ctrl_reg_data_hold, ext_data_lines_oe;
   logic mem_drive, host_drive;
   logic [1:0]             core_space;
   logic [ADDR_W-1:0]      core_addr, addr_pin, ext_addr_lines_o, ext_addr_lines_oe;
   logic [ADDR_W-1:0]      addr_keeper_o;
   logic [DATA_W-1:0]      core_wdata, core_rdata, host_rdata, host_wdata, mem_word;
   logic [DATA_W-1:0]      data_pin, ext_data_lines_o, data_keeper_o;
   logic [HOST_ADDR_W-1:0] host_addr, host_word;
   int                     err_count, checked, cycles;

   ext_bus_pins DUT (.clk, .sys_rst, .reset_in_n, .hold_req_n, .out_disable_n,
      .host_port_wide_select, .core_req, .core_write, .core_space, .core_addr, .core_wdata,
      .core_rdata, .host_read, .host_rdata, .host_addr, .host_wdata,
      .bank_switch_ctrl_reg_addr_hold, .bank_switch_ctrl_reg_data_hold, .hold_ack,
      .ext_addr_lines_i(addr_pin), .ext_addr_lines_o, .ext_addr_lines_oe, .addr_keeper_o,
      .addr_keeper_en, .ext_data_lines_i(data_pin), .ext_data_lines_o, .ext_data_lines_oe,
      .data_keeper_o, .data_keeper_en);

   ext_far_side far (.clk, .mem_drive, .mem_word, .host_drive, .host_word,
      .a_o(ext_addr_lines_o), .a_oe(ext_addr_lines_oe), .a_keep(addr_keeper_o),
      .a_keep_en(addr_keeper_en), .d_o(ext_data_lines_o), .d_oe(ext_data_lines_oe),
      .d_keep(data_keeper_o), .d_keep_en(data_keeper_en), .a_pin(addr_pin), .d_pin(data_pin));

   always #25 clk = ~clk;
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic stop_test();
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic req(input logic w, input logic [1:0] s, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      core_req = 1;
      core_write = w;
      core_space = s;
      core_addr = a;
      core_wdata = d;
      wait_n(2);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_spaces();
      logic [1:0]        sp [3] = '{SPACE_PROG, SPACE_DATA, SPACE_IO};
      logic [ADDR_W-1:0] a;
      for (int k = 0; k < 3; k++) begin
         req(1, sp[k], 23'h6b_c35a + 23'(k), 16'ha5c3 + 16'(k));
         a = (sp[k] == SPACE_PROG) ? core_addr : {7'h00, core_addr[15:0]};
         chk("addr_o", a, ext_addr_lines_o);
         chk("addr_oe", 23'h7f_ffff, ext_addr_lines_oe);
         chk("data_o", core_wdata, ext_data_lines_o);
         chk("data_oe", 1, ext_data_lines_oe);
         core_req = 0;
         wait_n(2);
         chk("data_oe_idle", 0, ext_data_lines_oe);
         chk("data_kept", core_wdata, data_pin);
         chk("addr_kept", a, addr_pin);
      end
   endtask
   task automatic t_float(input int k);
      req(1, SPACE_PROG, 23'h12_3456, 16'h3c96);
      hold_req_n = (k != 0);
      out_disable_n = (k != 1);
      reset_in_n = (k != 2);
      wait_n(5);
      chk("addr_oe_float", 0, ext_addr_lines_oe);
      chk("data_oe_float", 0, ext_data_lines_oe);
      chk("addr_kept_float", 23'h12_3456, addr_pin);
      chk("data_kept_float", 16'h3c96, data_pin);
      chk("hold_ack", k == 0, hold_ack);
      hold_req_n = 1;
      out_disable_n = 1;
      reset_in_n = 1;
      core_req = 0;
      wait_n(5);
   endtask
   task automatic t_read();
      mem_word = 16'hc3a5;
      mem_drive = 1;
      req(0, SPACE_DATA, 23'h00_0abc, 16'h0000);
      wait_n(4);
      chk("data_oe_read", 0, ext_data_lines_oe);
      chk("core_rdata", 16'hc3a5, core_rdata);
      core_req = 0;
      mem_drive = 0;
      wait_n(2);
   endtask
   task automatic t_wide();
      host_port_wide_select = 1;
      host_word = 18'h2_b4d1;
      host_drive = 1;
      host_read = 1;
      host_rdata = 16'h9e17;
      wait_n(3);
      req(0, SPACE_PROG, 23'h7f_0001, 16'h0000);
      wait_n(4);
      chk("addr_oe_wide", 0, ext_addr_lines_oe);
      chk("host_addr", 18'h2_b4d1, host_addr);
      chk("data_o_host", 16'h9e17, ext_data_lines_o);
      chk("data_oe_host", 1, ext_data_lines_oe);
      hold_req_n = 0;
      wait_n(4);
      chk("data_oe_host_hold", 0, ext_data_lines_oe);
      hold_req_n = 1;
      wait_n(4);
      host_read = 0;
      wait_n(2);
      mem_word = 16'h4812;
      mem_drive = 1;
      wait_n(5);
      chk("host_wdata", 16'h4812, host_wdata);
      host_port_wide_select = 0;
      host_drive = 0;
      mem_drive = 0;
      core_req = 0;
      wait_n(5);
   endtask
   task automatic t_holder();
      bank_switch_ctrl_reg_addr_hold = 0;
      bank_switch_ctrl_reg_data_hold = 0;
      wait_n(3);
      chk("addr_keep_en", 0, addr_keeper_en);
      chk("data_keep_en", 0, data_keeper_en);
      req(1, SPACE_DATA, 23'h00_0f0f, 16'h5a3c);
      core_req = 0;
      wait_n(2);
      chk("data_unkept", 16'ha5c3, data_pin);
      chk("addr_unkept", 23'h7f_f0f0, addr_pin);
      bank_switch_ctrl_reg_addr_hold = 1;
      bank_switch_ctrl_reg_data_hold = 1;
      wait_n(3);
      chk("data_keep_en_on", 1, data_keeper_en);
   endtask

   initial begin
      {clk, core_req, core_write, host_read, mem_drive, host_drive, host_port_wide_select} = '0;
      {sys_rst, reset_in_n, hold_req_n, out_disable_n} = 4'hf;
      {bank_switch_ctrl_reg_addr_hold, bank_switch_ctrl_reg_data_hold} = 2'h3;
      core_space = SPACE_PROG;
      {core_addr, core_wdata, host_rdata, mem_word, host_word} = '0;
      wait_n(21);
      sys_rst = 0;
      chk("addr_oe_rst", 0, ext_addr_lines_oe);
      // pin levels need two edges through the synchronisers and one more into the bus state
      wait_n(3);
      t_spaces();
      t_read();
      for (int k = 0; k < 3; k++) t_float(k);
      t_wide();
      t_holder();
      stop_test();
   end
endmodule
